// [logic/led_params.svh]
// constants for the network status indicator driver
// assumes a 125 MHz system clock
`ifndef LED_PARAMS_SVH
`define LED_PARAMS_SVH
`define LED_CLK_HZ 125000000
`define LED_BLINK_SLOW_HZ 10
`define LED_BLINK_FAST_HZ 20
// half period in cycles gives a 50 percent duty square wave
`define LED_SLOW_HALF_CYCLES (`LED_CLK_HZ / (2 * `LED_BLINK_SLOW_HZ))
`define LED_FAST_HALF_CYCLES (`LED_CLK_HZ / (2 * `LED_BLINK_FAST_HZ))
`define LED_DIV_WIDTH 23
`define LED_RESET_LEVEL 1'b0
`endif

// [logic/led_pkg.sv]
// types for the network status indicator driver
// assumes led_params.svh is compiled alongside
package led_pkg;
  typedef enum logic [1:0] {
    MODE_ONE = 2'b01,
    MODE_TWO = 2'b10
  } led_mode_t;
endpackage : led_pkg

// [logic/blink_divider.sv]
// rate divider giving a one-cycle enable pulse every half_cycles clocks
// assumes a single synchronous clock and active high synchronous reset
`timescale 1ns/10ps
`default_nettype none
`include "led_params.svh"
module blink_divider #(
  parameter logic [`LED_DIV_WIDTH-1:0] HALF_CYCLES = 23'd1
) (
  input wire logic sys_clk,
  input wire logic srst,
  output logic tick
);
  logic [`LED_DIV_WIDTH-1:0] count_reg;

  // count up, pulse tick for one cycle at terminal count
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      count_reg <= '0;
      tick <= 1'b0;
    end else if (count_reg == HALF_CYCLES - 23'd1) begin
      count_reg <= '0;
      tick <= 1'b1;
    end else begin
      count_reg <= count_reg + 23'd1;
      tick <= 1'b0;
    end
  end
endmodule : blink_divider
`default_nettype wire

// [logic/status_led_driver.sv]
// network status indicator driver: three led outputs from link state
// assumes link inputs synchronous to sys_clk; leds sit outside, high = on
`timescale 1ns/10ps
`default_nettype none
`include "led_params.svh"

module status_led_driver (
  input wire logic sys_clk,
  input wire logic srst,
  input wire led_pkg::led_mode_t led_mode,
  input wire logic link_good,
  input wire logic rx_active,
  input wire logic tx_active,
  input wire logic speed_100,
  input wire logic full_duplex,
  input wire logic collision,
  input wire logic aux_power_detect,
  input wire logic bus_power_detect,
  output logic link_activity_led,
  output logic speed_led,
  output logic duplex_collision_led,
  output logic aux_power_supported,
  output logic bus_power_supported
);
  import led_pkg::*;

  // one-cycle enables from the two rate dividers
  logic slow_tick;
  logic fast_tick;

  // square waves toggled on each enable
  logic slow_wave_reg;
  logic slow_wave_next;
  logic fast_wave_reg;
  logic fast_wave_next;

  // decoded mode and link conditions
  logic mode_two_sel;
  logic activity_seen;
  logic fast_link_up;
  logic slow_link_up;

  // next levels of the three leds
  logic link_activity_next;
  logic speed_next;
  logic duplex_collision_next;

  // next levels of the power flags
  logic aux_power_next;
  logic bus_power_next;

  // second meaning only for the exact mode 2 code
  function automatic logic is_mode_two(input led_mode_t mode);
    return mode == MODE_TWO;
  endfunction : is_mode_two

  // receive or transmit traffic in progress
  function automatic logic traffic_on(input logic rx, input logic tx);
    return rx | tx;
  endfunction : traffic_on

  // link up at one of the two speeds
  function automatic logic link_at(input logic good, input logic at_speed);
    return good & at_speed;
  endfunction : link_at

  // 10 Hz rate enable counted from sys_clk
  blink_divider #(
    .HALF_CYCLES(23'(`LED_SLOW_HALF_CYCLES))
  ) slow_div (
    .sys_clk(sys_clk),
    .srst(srst),
    .tick(slow_tick)
  );

  // 20 Hz rate enable counted from sys_clk
  blink_divider #(
    .HALF_CYCLES(23'(`LED_FAST_HALF_CYCLES))
  ) fast_div (
    .sys_clk(sys_clk),
    .srst(srst),
    .tick(fast_tick)
  );

  // wave next values, flip on each enable for half duty
  always_comb begin
    slow_wave_next = slow_wave_reg;
    fast_wave_next = fast_wave_reg;
    if (slow_tick) begin
      slow_wave_next = ~slow_wave_reg;
    end
    if (fast_tick) begin
      fast_wave_next = ~fast_wave_reg;
    end
  end

  // slow wave, restarts low at reset
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      slow_wave_reg <= 1'b0;
    end else begin
      slow_wave_reg <= slow_wave_next;
    end
  end

  // fast wave, restarts low at reset
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      fast_wave_reg <= 1'b0;
    end else begin
      fast_wave_reg <= fast_wave_next;
    end
  end

  // shared decode of mode select and link state
  always_comb begin
    mode_two_sel = is_mode_two(led_mode);
    activity_seen = traffic_on(rx_active, tx_active);
    fast_link_up = link_at(link_good, speed_100);
    slow_link_up = link_at(link_good, ~speed_100);
  end

  // link/activity led: steady on link in mode one only, blink on traffic in both meanings
  always_comb begin
    link_activity_next = 1'b0;
    if (mode_two_sel) begin
      link_activity_next = activity_seen & slow_wave_reg;
    end else if (activity_seen) begin
      link_activity_next = slow_wave_reg;
    end else begin
      link_activity_next = link_good;
    end
  end

  // speed led: 100 Mb/s in both meanings
  always_comb begin
    speed_next = 1'b0;
    if (mode_two_sel) begin
      speed_next = fast_link_up;
    end else begin
      speed_next = fast_link_up;
    end
  end

  // duplex/collision led: duplex and collisions, or 10 Mb/s link
  always_comb begin
    duplex_collision_next = 1'b0;
    if (mode_two_sel) begin
      duplex_collision_next = slow_link_up;
    end else if (full_duplex) begin
      duplex_collision_next = 1'b1;
    end else begin
      duplex_collision_next = collision & fast_wave_reg;
    end
  end

  // power flags follow their detect pins
  always_comb begin
    aux_power_next = aux_power_detect;
    bus_power_next = bus_power_detect;
  end

  // link/activity led register
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      link_activity_led <= `LED_RESET_LEVEL;
    end else begin
      link_activity_led <= link_activity_next;
    end
  end

  // speed led register
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      speed_led <= `LED_RESET_LEVEL;
    end else begin
      speed_led <= speed_next;
    end
  end

  // duplex/collision led register
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      duplex_collision_led <= `LED_RESET_LEVEL;
    end else begin
      duplex_collision_led <= duplex_collision_next;
    end
  end

  // auxiliary power flag register
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      aux_power_supported <= 1'b0;
    end else begin
      aux_power_supported <= aux_power_next;
    end
  end

  // bus power flag register
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      bus_power_supported <= 1'b0;
    end else begin
      bus_power_supported <= bus_power_next;
    end
  end
endmodule : status_led_driver
`default_nettype wire

// [verification/led_checker.sv]
// port checker for the status led driver
// assumes one clock, synchronous active high reset
`timescale 1ns/10ps
`default_nettype none
module led_checker (
  input wire logic sys_clk, srst, link_good, rx_active, tx_active, speed_100,
  input wire logic full_duplex, collision, aux_power_detect, bus_power_detect,
  input wire logic link_activity_led, speed_led, duplex_collision_led,
  input wire logic aux_power_supported, bus_power_supported,
  input wire led_pkg::led_mode_t led_mode
);
  import led_pkg::*;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);
  // mode decode, quiet while in reset
  wire logic one = !srst && led_mode != MODE_TWO;
  wire logic two = !srst && led_mode == MODE_TWO;
  wire logic idle = !rx_active && !tx_active;
  sequence link_quiet; one && link_good && idle; endsequence
  a_link_steady: assert property (link_quiet |=> link_activity_led)
    else $error("link led not on");
  a_act_quiet: assert property (two && idle |=> !link_activity_led)
    else $error("activity led lit while idle");
  a_speed_one: assert property (one |=> speed_led == $past(link_good && speed_100))
    else $error("speed led wrong in mode one");
  a_speed_two: assert property (two |=> speed_led == $past(link_good && speed_100))
    else $error("fast link led wrong");
  a_duplex_on: assert property (one && full_duplex |=> duplex_collision_led)
    else $error("duplex led off in full duplex");
  a_half_quiet: assert property (one && !full_duplex && !collision |=> !duplex_collision_led)
    else $error("duplex led lit without collision");
  a_slow_link: assert property (two |=> duplex_collision_led == $past(link_good && !speed_100))
    else $error("slow link led wrong");
  a_aux_follow: assert property (!srst |=> aux_power_supported == $past(aux_power_detect))
    else $error("aux power flag wrong");
  a_bus_follow: assert property (!srst |=> bus_power_supported == $past(bus_power_detect))
    else $error("bus power flag wrong");
endmodule : led_checker
bind status_led_driver led_checker chk (.*);
`default_nettype wire

// [verification/status_leds.sv]
// three indicator lamps on the led pins, high = lit
`timescale 1ns/10ps
`default_nettype none
module status_leds (
  input wire logic link_activity_led, speed_led, duplex_collision_led,
  output logic [2:0] lit
);
  // lamps follow their pins with no delay
  assign lit = {link_activity_led, speed_led, duplex_collision_led};
endmodule : status_leds
`default_nettype wire

// [verification/tb_status_led_driver.sv]
// random link states; blink waves stay in their low half for this short run
`timescale 1ns/10ps
`default_nettype none
module tb_status_led_driver;
  import led_pkg::*;
  logic sys_clk = 0, srst = 1, link_good = 0, rx_active = 0, tx_active = 0, speed_100 = 0;
  logic full_duplex = 0, collision = 0, aux_power_detect = 0, bus_power_detect = 0;
  logic link_activity_led, speed_led, duplex_collision_led, aux_power_supported;
  logic bus_power_supported;
  led_mode_t led_mode = MODE_ONE;
  logic [2:0] lit;
  logic [4:0] q[$];
  int n_errors = 0, n_checks = 0, cyc = 0;
  status_led_driver uut (.*);
  status_leds leds (.link_activity_led, .speed_led, .duplex_collision_led, .lit);
  task automatic check(input logic [4:0] seen, input logic [4:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch leds exp %b seen %b", exp, seen);
    end
  endtask : check
  task automatic wrap_up;
    if (n_errors == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : wrap_up
  // fixed known clock standing in for the board reference
  initial forever #4 sys_clk = ~sys_clk;
  // hang guard
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_errors++;
      wrap_up();
    end
  end
  // results show one edge after the inputs are taken
  always @(negedge sys_clk) if (q.size() > 1)
    check({lit, aux_power_supported, bus_power_supported}, q.pop_front());
  initial begin
    logic [8:0] r;
    void'($urandom(32'hcea6));
    repeat (20) @(posedge sys_clk);
    srst <= 1'b0;
    @(posedge sys_clk);
    repeat (1000) begin
      @(posedge sys_clk);
      r = 9'($urandom);
      led_mode <= r[0] ? MODE_ONE : MODE_TWO;
      {collision, speed_100, tx_active, rx_active, link_good} <= {r[6], r[4:1]};
      full_duplex <= r[5] & r[1];
      {bus_power_detect, aux_power_detect} <= r[8:7];
      if (r[0]) q.push_back({r[1] & !r[2] & !r[3], r[1] & r[4], r[5] & r[1], r[7], r[8]});
      else q.push_back({1'b0, r[1] & r[4], r[1] & !r[4], r[7], r[8]});
    end
    repeat (2) @(posedge sys_clk);
    wrap_up();
  end
endmodule : tb_status_led_driver
`default_nettype wire
